// ==== include/dmx_pkg.sv ====
package dmx_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_SWREQ = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_TEMP = 8'h10;
  // Channel blocks at 0x40 + 0x10*ch, word index in [3:2]
  localparam logic [1:0] CH_REGION = 2'h1;
  localparam logic [1:0] SUB_ADDR = 2'h0;
  localparam logic [1:0] SUB_CNT = 2'h1;
  localparam logic [1:0] SUB_MODE = 2'h2;
  // Command register bits
  localparam int CMD_M2M = 0;
  localparam int CMD_HOLD0 = 1;
  localparam int CMD_ROT = 2;
  localparam int CMD_DIS = 3;
  localparam int CMD_GPOL = 7;
  // Mode register fields
  localparam int MD_TYPE_LSB = 0;
  localparam int MD_AUTO = 2;
  localparam int MD_DOWN = 3;
  localparam int MD_MODE_LSB = 4;
  localparam logic [1:0] XT_VERIFY = 2'h0;
  localparam logic [1:0] XT_WRITE = 2'h1;
  localparam logic [1:0] XT_READ = 2'h2;
  localparam logic [1:0] TM_DEMAND = 2'h0;
  localparam logic [1:0] TM_SINGLE = 2'h1;
  localparam logic [1:0] TM_BLOCK = 2'h2;
  localparam logic [1:0] TM_CASCADE = 2'h3;
  // Reset values
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'hF;
  localparam logic [3:0] GRANT_RST = 4'hF;
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_HOLD, ST_ADDR, ST_RDWR, ST_WAIT, ST_DONE, ST_CASC, ST_REL
  } dmx_state_t;
endpackage

// ==== src/dmx_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module dmx_sync #(
  parameter int W = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dmx_sync_t;
  dmx_sync_t r;
  dmx_sync_t n;

  // A change is taken only once the second and third stages agree
  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.q[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.q;
endmodule
`default_nettype wire

// ==== src/dmx_engine.sv ====
// Behaviour
// - Single mode: one transfer, drop hold request, rearbitrate after hold grant falls.
// - Each transfer decrements count and steps address up or down per mode bit.
// - Count rolling 0000H to FFFFH sets status bit and pulses terminal_count.
// - Terminal count without autoinit sets channel mask and stops service.
// - Block mode starts on hardware or software request, runs to terminal count.
// - Demand mode runs while request stays high, stops at terminal count.
// - Cascade: request/grant act as downstream hold; no address or strobes.
// - Channel 0 is wired internally in cascade to the byte controller.
// - Reset makes grants active low and drives them inactive.
// - Read transfer: memory address, mem_read_strobe and io_write_strobe together.
// - Write transfer: memory address, mem_write_strobe and io_read_strobe together.
// - Verify: normal sequencing, no strobes, io_channel_ready ignored.
// - Memory-to-memory on channels 0 and 1, enabled by command bit, started on 0.
// - Channel 0 reads into temp register, channel 1 writes it, ends on 1's count.
// - Optional hold of channel 0 source address during memory-to-memory.
// - Autoinit reloads current from base; transfers never touch base registers.
// - Autoinitializing channel keeps its mask bit cleared at terminal count.
// - Fixed priority: channel 0 highest, 3 lowest, no preemption of service.
// - Rotating priority: last serviced channel drops to lowest, order kept cyclic.
// - Hold request raised, arbitration open until hold grant, then frozen.
// - Hold request on unmasked hardware or software request; cycles after grant.
`timescale 1ns/100ps
`default_nettype none
module dmx_engine (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] channel_request_in,
  output logic [3:0] channel_grant_out,
  output logic bus_hold_request,
  input wire logic bus_hold_grant,
  output logic terminal_count,
  output logic [15:0] mem_addr_out,
  output logic mem_addr_enable,
  output logic mem_read_strobe,
  output logic mem_write_strobe,
  output logic io_read_strobe,
  output logic io_write_strobe,
  input wire logic io_channel_ready,
  input wire logic [7:0] local_data_in,
  output logic [7:0] local_data_out,
  output logic local_data_oe,
  input wire logic internal_cascade_en,
  input wire logic byte_ctrl_hold_request,
  output logic byte_ctrl_hold_grant
);
  typedef struct packed {
    dmx_pkg::dmx_state_t st;
    logic [1:0] act;
    logic [1:0] last;
    logic wr_phase;
    logic [7:0] cmd;
    logic [3:0] mask;
    logic [3:0] swreq;
    logic [3:0] tcs;
    logic [3:0][15:0] base_addr;
    logic [3:0][15:0] base_cnt;
    logic [3:0][15:0] cur_addr;
    logic [3:0][15:0] cur_cnt;
    logic [3:0][5:0] mode;
    logic [7:0] temp;
    logic hreq;
    logic tcp;
    logic mr;
    logic mw;
    logic ior;
    logic iow;
    logic [15:0] addr;
    logic aen;
    logic [7:0] dout;
    logic doe;
    logic [3:0] grant;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
  } dmx_regs_t;

  localparam dmx_regs_t REGS_RST = '{
    st: dmx_pkg::ST_IDLE, act: 2'h0, last: 2'h3, wr_phase: 1'b0,
    cmd: dmx_pkg::CMD_RST, mask: dmx_pkg::MASK_RST, swreq: 4'h0, tcs: 4'h0,
    base_addr: '0, base_cnt: '0, cur_addr: '0, cur_cnt: '0,
    mode: '0, temp: 8'h00, hreq: 1'b0, tcp: 1'b0,
    mr: 1'b0, mw: 1'b0, ior: 1'b0, iow: 1'b0,
    addr: dmx_pkg::WORD_ZERO, aen: 1'b0, dout: 8'h00, doe: 1'b0,
    grant: dmx_pkg::GRANT_RST, dp_wr: 1'b0, dp_addr: 8'h00, rdata: 32'h0000_0000
  };

  dmx_regs_t r;
  dmx_regs_t n;
  logic [5:0] sync_q;
  logic [3:0] req_s;
  logic hlda_s;
  logic rdy_s;

  // Pins from the bus side pass the three-stage filter
  dmx_sync #(.W(6)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({io_channel_ready, bus_hold_grant, channel_request_in}),
    .q(sync_q)
  );
  assign req_s = sync_q[3:0];
  assign hlda_s = sync_q[4];
  assign rdy_s = sync_q[5];

  always_comb begin
    logic [3:0] req_eff;
    logic [3:0] pend;
    logic [3:0] upd;
    logic [3:0] oh;
    logic [1:0] start;
    logic [1:0] idx;
    logic [1:0] win;
    logic [1:0] sel;
    logic [1:0] tmode;
    logic [1:0] xtype;
    logic found;
    logic m2m_act;
    logic ended;
    logic cascade_now;
    logic [1:0] ch;
    logic [31:0] rd_val;
    req_eff = req_s;
    pend = 4'h0;
    upd = 4'h0;
    oh = 4'h0;
    start = 2'h0;
    idx = 2'h0;
    win = 2'h0;
    sel = 2'h0;
    tmode = 2'h0;
    xtype = 2'h0;
    found = 1'b0;
    m2m_act = 1'b0;
    ended = 1'b0;
    cascade_now = 1'b0;
    ch = 2'h0;
    rd_val = 32'h0000_0000;
    n = r;
    n.tcp = 1'b0;
    n.dp_wr = 1'b0;

    // Byte controller hold request enters on channel 0 without a synchroniser
    if (internal_cascade_en) begin
      req_eff[0] = byte_ctrl_hold_request;
    end

    // Bus address phase; read data is prepared here for the data phase
    if (hsel && htrans[1] && hready) begin
      n.dp_wr = hwrite;
      n.dp_addr = haddr[7:0];
      if (!hwrite) begin
        ch = haddr[5:4];
        case (haddr[7:0])
          dmx_pkg::REG_CMD: rd_val = {24'h000000, r.cmd};
          dmx_pkg::REG_MASK: rd_val = {28'h0000000, r.mask};
          dmx_pkg::REG_SWREQ: rd_val = {28'h0000000, r.swreq};
          dmx_pkg::REG_STATUS: rd_val = {24'h000000, req_eff, r.tcs};
          dmx_pkg::REG_TEMP: rd_val = {24'h000000, r.temp};
          default: begin
            if (haddr[7:6] == dmx_pkg::CH_REGION && haddr[1:0] == 2'h0) begin
              case (haddr[3:2])
                dmx_pkg::SUB_ADDR: rd_val = {16'h0000, r.cur_addr[ch]};
                dmx_pkg::SUB_CNT: rd_val = {16'h0000, r.cur_cnt[ch]};
                dmx_pkg::SUB_MODE: rd_val = {26'h0, r.mode[ch]};
                default: rd_val = 32'h0000_0000;
              endcase
            end
          end
        endcase
        n.rdata = rd_val;
        // Status read clears the sticky bits; a set later in this cycle still wins
        if (haddr[7:0] == dmx_pkg::REG_STATUS) begin
          n.tcs = 4'h0;
        end
      end
    end

    // Bus data phase write
    if (r.dp_wr) begin
      ch = r.dp_addr[5:4];
      case (r.dp_addr)
        dmx_pkg::REG_CMD: n.cmd = hwdata[7:0];
        dmx_pkg::REG_MASK: n.mask = hwdata[3:0];
        dmx_pkg::REG_SWREQ: n.swreq = hwdata[3:0];
        default: begin
          if (r.dp_addr[7:6] == dmx_pkg::CH_REGION && r.dp_addr[1:0] == 2'h0) begin
            case (r.dp_addr[3:2])
              dmx_pkg::SUB_ADDR: begin
                n.base_addr[ch] = hwdata[15:0];
                n.cur_addr[ch] = hwdata[15:0];
              end
              dmx_pkg::SUB_CNT: begin
                n.base_cnt[ch] = hwdata[15:0];
                n.cur_cnt[ch] = hwdata[15:0];
              end
              dmx_pkg::SUB_MODE: n.mode[ch] = hwdata[5:0];
              default: n.mode[ch] = r.mode[ch];
            endcase
          end
        end
      endcase
    end

    // Pending requests: unmasked hardware or any software request
    for (int i = 0; i < 4; i++) begin
      pend[i] = ((req_eff[i] && !r.mask[i]) || r.swreq[i]) && !r.cmd[dmx_pkg::CMD_DIS];
    end
    if (r.cmd[dmx_pkg::CMD_M2M]) begin
      pend[1] = 1'b0;
    end

    // Fixed order starts at 0, rotating starts after the last serviced
    start = r.cmd[dmx_pkg::CMD_ROT] ? r.last + 2'h1 : 2'h0;
    for (int i = 0; i < 4; i++) begin
      idx = start + 2'(i);
      if (!found && pend[idx]) begin
        found = 1'b1;
        win = idx;
      end
    end

    tmode = r.mode[r.act][dmx_pkg::MD_MODE_LSB +: 2];
    xtype = r.mode[r.act][dmx_pkg::MD_TYPE_LSB +: 2];
    m2m_act = r.cmd[dmx_pkg::CMD_M2M] && r.act == 2'h0;

    case (r.st)
      dmx_pkg::ST_IDLE: begin
        if (|pend) begin
          n.hreq = 1'b1;
          n.st = dmx_pkg::ST_HOLD;
        end
      end
      dmx_pkg::ST_HOLD: begin
        // Arbitration stays open until the hold grant, then the winner is frozen
        if (!(|pend)) begin
          n.hreq = 1'b0;
          n.st = dmx_pkg::ST_IDLE;
        end else if (hlda_s) begin
          n.act = win;
          n.last = win;
          n.wr_phase = 1'b0;
          cascade_now = r.mode[win][dmx_pkg::MD_MODE_LSB +: 2] == dmx_pkg::TM_CASCADE;
          if (win == 2'h0 && internal_cascade_en) begin
            cascade_now = 1'b1;
          end
          n.st = cascade_now ? dmx_pkg::ST_CASC : dmx_pkg::ST_ADDR;
        end
      end
      dmx_pkg::ST_ADDR: n.st = dmx_pkg::ST_RDWR;
      dmx_pkg::ST_RDWR: n.st = dmx_pkg::ST_WAIT;
      dmx_pkg::ST_WAIT: begin
        if ((!m2m_act && xtype == dmx_pkg::XT_VERIFY) || rdy_s) begin
          if (m2m_act && !r.wr_phase) begin
            n.temp = local_data_in;
            n.wr_phase = 1'b1;
            n.st = dmx_pkg::ST_ADDR;
          end else begin
            n.st = dmx_pkg::ST_DONE;
          end
        end
      end
      dmx_pkg::ST_DONE: begin
        if (m2m_act) begin
          upd = 4'b0011;
        end else begin
          upd[r.act] = 1'b1;
        end
        for (int c = 0; c < 4; c++) begin
          if (upd[c]) begin
            if (!(c == 0 && m2m_act && r.cmd[dmx_pkg::CMD_HOLD0])) begin
              n.cur_addr[c] = r.mode[c][dmx_pkg::MD_DOWN] ? r.cur_addr[c] - 16'h0001
                                                           : r.cur_addr[c] + 16'h0001;
            end
            n.cur_cnt[c] = r.cur_cnt[c] - 16'h0001;
            if (r.cur_cnt[c] == 16'h0000) begin
              if (r.mode[c][dmx_pkg::MD_AUTO]) begin
                n.cur_addr[c] = r.base_addr[c];
                n.cur_cnt[c] = r.base_cnt[c];
              end
              if (!m2m_act || c == 1) begin
                ended = 1'b1;
                n.tcp = 1'b1;
                n.tcs[c] = 1'b1;
                n.swreq[r.act] = 1'b0;
                // Autoinit leaves the mask alone so service carries on
                if (!r.mode[c][dmx_pkg::MD_AUTO]) begin
                  n.mask[r.act] = 1'b1;
                end
              end
            end
          end
        end
        n.wr_phase = 1'b0;
        case (tmode)
          dmx_pkg::TM_SINGLE: n.st = dmx_pkg::ST_REL;
          dmx_pkg::TM_BLOCK: n.st = ended ? dmx_pkg::ST_REL : dmx_pkg::ST_ADDR;
          default: begin
            if (ended || !(req_eff[r.act] || r.swreq[r.act])) begin
              n.st = dmx_pkg::ST_REL;
            end else begin
              n.st = dmx_pkg::ST_ADDR;
            end
          end
        endcase
        if (n.st == dmx_pkg::ST_REL) begin
          n.hreq = 1'b0;
        end
      end
      dmx_pkg::ST_CASC: begin
        // Only the active request is watched while the downstream owns the bus
        if (!req_eff[r.act]) begin
          n.hreq = 1'b0;
          n.st = dmx_pkg::ST_REL;
        end
      end
      dmx_pkg::ST_REL: begin
        // New arbitration waits for the hold grant to fall
        if (!hlda_s) begin
          n.st = dmx_pkg::ST_IDLE;
        end
      end
      default: begin
        n.hreq = 1'b0;
        n.st = dmx_pkg::ST_IDLE;
      end
    endcase

    // Outputs registered from the next state
    sel = n.wr_phase ? 2'h1 : n.act;
    xtype = n.mode[n.act][dmx_pkg::MD_TYPE_LSB +: 2];
    m2m_act = n.cmd[dmx_pkg::CMD_M2M] && n.act == 2'h0;
    n.aen = n.st == dmx_pkg::ST_ADDR || n.st == dmx_pkg::ST_RDWR || n.st == dmx_pkg::ST_WAIT;
    n.addr = n.aen ? n.cur_addr[sel] : dmx_pkg::WORD_ZERO;
    n.mr = 1'b0;
    n.mw = 1'b0;
    n.ior = 1'b0;
    n.iow = 1'b0;
    n.doe = 1'b0;
    if (n.st == dmx_pkg::ST_RDWR || n.st == dmx_pkg::ST_WAIT) begin
      if (m2m_act) begin
        n.mr = !n.wr_phase;
        n.mw = n.wr_phase;
        n.doe = n.wr_phase;
      end else if (xtype == dmx_pkg::XT_READ) begin
        n.mr = 1'b1;
        n.iow = 1'b1;
      end else if (xtype == dmx_pkg::XT_WRITE) begin
        n.mw = 1'b1;
        n.ior = 1'b1;
      end
    end
    n.dout = n.doe ? n.temp : 8'h00;
    if (n.st == dmx_pkg::ST_ADDR || n.st == dmx_pkg::ST_RDWR || n.st == dmx_pkg::ST_WAIT ||
        n.st == dmx_pkg::ST_DONE || n.st == dmx_pkg::ST_CASC) begin
      oh[n.act] = 1'b1;
    end
    n.grant = n.cmd[dmx_pkg::CMD_GPOL] ? oh : ~oh;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= REGS_RST;
    end else begin
      r <= n;
    end
  end

  // Zero-wait slave; unmapped words read zero and ignore writes
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign channel_grant_out = r.grant;
  assign bus_hold_request = r.hreq;
  assign terminal_count = r.tcp;
  assign mem_addr_out = r.addr;
  assign mem_addr_enable = r.aen;
  assign mem_read_strobe = r.mr;
  assign mem_write_strobe = r.mw;
  assign io_read_strobe = r.ior;
  assign io_write_strobe = r.iow;
  assign local_data_out = r.dout;
  assign local_data_oe = r.doe;
  assign byte_ctrl_hold_grant = internal_cascade_en && r.st == dmx_pkg::ST_CASC && r.act == 2'h0;
endmodule
`default_nettype wire

// ==== testbench/dmx_engine_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module dmx_engine_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] channel_grant_out,
  input wire logic bus_hold_request,
  input wire logic bus_hold_grant,
  input wire logic terminal_count,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_addr_enable,
  input wire logic mem_read_strobe,
  input wire logic mem_write_strobe,
  input wire logic io_read_strobe,
  input wire logic io_write_strobe,
  input wire logic internal_cascade_en,
  input wire logic byte_ctrl_hold_grant
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Grant only falls once the hold grant has been seen for a while
  property p_grant_after_hold;
    $fell(&channel_grant_out) |-> bus_hold_request && $past(bus_hold_grant, 2);
  endproperty
  a_grant_after_hold: assert property (p_grant_after_hold) else $error("grant without hold grant");
  property p_no_switch;
    $changed(channel_grant_out) |-> $past(channel_grant_out) == 4'hF || channel_grant_out == 4'hF;
  endproperty
  a_no_switch: assert property (p_no_switch) else $error("grant moved between channels");
  property p_rd_pair;
    io_write_strobe |-> mem_read_strobe;
  endproperty
  a_rd_pair: assert property (p_rd_pair) else $error("io write without memory read");
  property p_wr_pair;
    io_read_strobe |-> mem_write_strobe;
  endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("io read without memory write");
  property p_strobe_addr;
    (mem_read_strobe || mem_write_strobe) |-> mem_addr_enable;
  endproperty
  a_strobe_addr: assert property (p_strobe_addr) else $error("strobe without address");
  property p_tc_pulse;
    terminal_count |=> !terminal_count;
  endproperty
  a_tc_pulse: assert property (p_tc_pulse) else $error("terminal count longer than one cycle");
  property p_tc_stop;
    terminal_count |-> $fell(bus_hold_request);
  endproperty
  a_tc_stop: assert property (p_tc_stop) else $error("hold request kept at terminal count");
  property p_rearm;
    $rose(bus_hold_request) |-> !bus_hold_grant && !$past(bus_hold_grant);
  endproperty
  a_rearm: assert property (p_rearm) else $error("hold request before hold grant fell");
  property p_casc_quiet;
    byte_ctrl_hold_grant |-> !(mem_addr_enable || mem_read_strobe || mem_write_strobe || io_read_strobe);
  endproperty
  a_casc_quiet: assert property (p_casc_quiet) else $error("cascade drove address or strobes");
  property p_casc_grant;
    byte_ctrl_hold_grant |-> internal_cascade_en && !channel_grant_out[0];
  endproperty
  a_casc_grant: assert property (p_casc_grant) else $error("cascade grant not on channel 0");
  // Memory-to-memory moves from source to destination address as the read strobe falls
  property p_addr_stable;
    mem_addr_enable && $past(mem_addr_enable) && !$fell(mem_read_strobe) |-> $stable(mem_addr_out);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved inside transfer");
endmodule
bind dmx_engine dmx_engine_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .channel_grant_out(channel_grant_out),
  .bus_hold_request(bus_hold_request), .bus_hold_grant(bus_hold_grant), .terminal_count(terminal_count),
  .mem_addr_out(mem_addr_out), .mem_addr_enable(mem_addr_enable), .mem_read_strobe(mem_read_strobe),
  .mem_write_strobe(mem_write_strobe), .io_read_strobe(io_read_strobe), .io_write_strobe(io_write_strobe),
  .internal_cascade_en(internal_cascade_en), .byte_ctrl_hold_grant(byte_ctrl_hold_grant)
);
`default_nettype wire

// ==== testbench/dmx_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dmx_far_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] lat,
  input wire logic bus_hold_request,
  input wire logic mem_read_strobe,
  input wire logic mem_write_strobe,
  output logic bus_hold_grant,
  output logic io_channel_ready,
  output logic [7:0] local_data_in
);
  logic [3:0] cnt_q;
  logic [1:0] wt_q;
  // Byte source idles at the inverse so a stale sample cannot pass
  assign local_data_in = mem_read_strobe ? 8'hA5 : 8'h5A;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      wt_q <= 2'h0;
      bus_hold_grant <= 1'b0;
      io_channel_ready <= 1'b0;
    end else begin
      // Hold grant after a chosen delay, withdrawn as soon as the request goes
      if (!bus_hold_request) begin
        cnt_q <= 4'h0;
        bus_hold_grant <= 1'b0;
      end else if (cnt_q == lat) begin
        bus_hold_grant <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
      // Ready after three strobe cycles, then held until the strobes drop: a pulse would not pass the filter
      if (!(mem_read_strobe || mem_write_strobe)) begin
        wt_q <= 2'h0;
      end else if (wt_q != 2'h2) begin
        wt_q <= wt_q + 2'h1;
      end
      io_channel_ready <= (mem_read_strobe || mem_write_strobe) && wt_q == 2'h2;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_dmx_engine.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_dmx_engine;
  typedef struct {logic [1:0] ch; logic [5:0] md; logic sw; logic hold; logic [15:0] a; logic [15:0] c;
    logic [15:0] ea; logic [15:0] ec; logic [3:0] mk; logic [3:0] nh;} dmx_row_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cas = 0, bhr = 0, hready, hreadyout, hresp, hreq, hgnt;
  logic tcp, aen, mrd, mwr, ird, iwr, rdy, bhg, ldoe;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [3:0] req = 4'h0, lat = 4'h0, gnt, gp;
  logic [15:0] maddr;
  logic [7:0] ldi, ldo, ld_seen, b;
  logic [3:0] gq[$];
  int fails = 0, num_checks = 0, cyc = 0, nt, nh, ns, k;
  logic ap, hp;
  dmx_row_t r;
  dmx_row_t rows[4] = '{
    '{2'd0, 6'h12, 1'b0, 1'b1, 16'h0010, 16'h0001, 16'h0012, 16'hFFFF, 4'hF, 4'd2},
    '{2'd1, 6'h29, 1'b0, 1'b0, 16'h0100, 16'h0002, 16'h00FD, 16'hFFFF, 4'hF, 4'd1},
    '{2'd2, 6'h04, 1'b0, 1'b1, 16'h0200, 16'h0000, 16'h0200, 16'h0000, 4'hB, 4'd1},
    '{2'd3, 6'h22, 1'b1, 1'b0, 16'h0300, 16'h0001, 16'h0302, 16'hFFFF, 4'hF, 4'd1}};
  assign hready = hreadyout;
  dmx_engine u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .channel_request_in(req), .channel_grant_out(gnt), .bus_hold_request(hreq),
    .bus_hold_grant(hgnt), .terminal_count(tcp), .mem_addr_out(maddr), .mem_addr_enable(aen),
    .mem_read_strobe(mrd), .mem_write_strobe(mwr), .io_read_strobe(ird), .io_write_strobe(iwr),
    .io_channel_ready(rdy), .local_data_in(ldi), .local_data_out(ldo), .local_data_oe(ldoe),
    .internal_cascade_en(cas), .byte_ctrl_hold_request(bhr), .byte_ctrl_hold_grant(bhg));
  dmx_far_model u_far (.hclk(hclk), .hresetn(hresetn), .lat(lat), .bus_hold_request(hreq),
    .mem_read_strobe(mrd), .mem_write_strobe(mwr), .bus_hold_grant(hgnt), .io_channel_ready(rdy),
    .local_data_in(ldi));
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    gp <= gnt;
    ap <= aen;
    hp <= hreq;
    if (gp === 4'hF && gnt !== 4'hF) gq.push_back(gnt);
    if (!ap && aen === 1'b1) nt++;
    if (!hp && hreq === 1'b1) nh++;
    if (mrd === 1'b1 || mwr === 1'b1) ns++;
    if (ldoe === 1'b1) ld_seen <= ldo;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address phase held until ready, data phase likewise; read data taken at the closing edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  task automatic prog(input logic [1:0] ch, input logic [15:0] a, input logic [15:0] c, input logic [5:0] md);
    wr(8'h40 + {2'h0, ch, 4'h0}, {16'h0, a});
    wr(8'h44 + {2'h0, ch, 4'h0}, {16'h0, c});
    wr(8'h48 + {2'h0, ch, 4'h0}, {26'h0, md});
  endtask
  task automatic rq(input logic [3:0] x);
    @(posedge hclk);
    req <= x;
  endtask
  // A wait that runs out shows up as a missing count pulse
  task automatic wait_end();
    for (k = 0; k < 600 && tcp !== 1'b1; k++) @(negedge hclk);
    chk({31'h0, tcp}, 32'h1);
    for (k = 0; k < 600 && hreq !== 1'b0; k++) @(negedge hclk);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk({28'h0, gnt}, 32'hF);
    foreach (rows[i]) begin
      r = rows[i];
      b = 8'h40 + {2'h0, r.ch, 4'h0};
      prog(r.ch, r.a, r.c, r.md);
      wr(dmx_pkg::REG_MASK, {28'h0, ~(4'h1 << r.ch)});
      nt = 0;
      nh = 0;
      ns = 0;
      // Peripheral keeps its request up at least until its grant shows
      if (r.sw) wr(dmx_pkg::REG_SWREQ, {28'h0, 4'h1 << r.ch});
      else rq(4'h1 << r.ch);
      for (k = 0; k < 300 && gnt[r.ch] !== 1'b0; k++) @(negedge hclk);
      if (!r.hold) rq(4'h0);
      wait_end();
      rq(4'h0);
      chk(nt, {16'h0, r.c} + 32'h1);
      chk(nh, {28'h0, r.nh});
      chk(ns != 0, r.md[1:0] != dmx_pkg::XT_VERIFY);
      rdchk(b, {16'h0, r.ea});
      rdchk(b + 8'h04, {16'h0, r.ec});
      rdchk(dmx_pkg::REG_MASK, {28'h0, r.mk});
      rdchk(dmx_pkg::REG_STATUS, {28'h0, 4'h1 << r.ch});
      rdchk(dmx_pkg::REG_SWREQ, 32'h0);
    end
    // Late higher request must still win while hold grant is slow
    lat <= 4'h8;
    for (int m = 0; m < 2; m++) begin
      wr(dmx_pkg::REG_CMD, m ? 32'h4 : 32'h0);
      prog(2'd0, 16'h0, 16'h1, 6'h10);
      prog(2'd1, 16'h0, 16'h1, 6'h10);
      wr(dmx_pkg::REG_MASK, 32'hC);
      gq.delete();
      rq(4'h2);
      rq(4'h3);
      for (k = 0; k < 900 && gq.size() < 4; k++) @(negedge hclk);
      rq(4'h0);
      chk(gq.size(), 4);
      chk(gq[0], 4'hE);
      chk(gq[1], m ? 4'hD : 4'hE);
      chk(gq[2], m ? 4'hE : 4'hD);
    end
    lat <= 4'h0;
    // Mem-to-mem fill: source address held, equal counts on both channels
    wr(dmx_pkg::REG_CMD, 32'h3);
    prog(2'd0, 16'h0300, 16'h1, 6'h22);
    prog(2'd1, 16'h0400, 16'h1, 6'h22);
    wr(dmx_pkg::REG_MASK, 32'hC);
    wr(dmx_pkg::REG_SWREQ, 32'h1);
    wait_end();
    rdchk(8'h40, 32'h0300);
    rdchk(8'h50, 32'h0402);
    rdchk(dmx_pkg::REG_TEMP, 32'hA5);
    chk(ld_seen, 8'hA5);
    wr(dmx_pkg::REG_CMD, 32'h0);
    wr(dmx_pkg::REG_MASK, 32'hE);
    @(posedge hclk);
    cas <= 1'b1;
    bhr <= 1'b1;
    for (k = 0; k < 300 && bhg !== 1'b1; k++) @(negedge hclk);
    chk({aen, gnt}, 5'h0E);
    @(posedge hclk);
    bhr <= 1'b0;
    for (k = 0; k < 300 && hreq !== 1'b0; k++) @(negedge hclk);
    chk(bhg, 1'b0);
    @(posedge hclk);
    cas <= 1'b0;
    hresetn <= 1'b0;
    @(negedge hclk);
    chk({hreq, gnt}, 5'h0F);
    @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(dmx_pkg::REG_MASK, 32'hF);
    rdchk(dmx_pkg::REG_CMD, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
